/* core/pvmr_top.sv */
// pvmr_top: upper management register set of the integrated 10/100 PHY
// assumes: event and negotiation inputs come from PHY logic on clk_sys_in;
// straps and line energy come from pins and are synchronised here
//
// Notes on behaviour
// - expansion bit 4 latches high on parallel detection fault, else reads zero
// - expansion bit 1 latches high on a new received page, else zero
// - expansion bit 0 partner able, bit 3 partner next page, bit 2 zero
// - mode control bit 13 enables energy-detect power-down, resets to zero
// - energy-present falls after 256 ms without energy, one while energy present
// - hardware reset sets energy-present, software reset leaves it alone
// - special modes bits 4:0 hold the management address, default 00001
// - modes 000 to 011 force 10/100 half/full without negotiation
// - modes 100 and 101 negotiate 100 half only; 101 carrier on receive only
// - mode 111 advertises 1111 and speed/duplex follow negotiation outcome
// - override bit 15 zero: strap governs crossover; one: bits 14 and 13
// - bit 14 enables auto crossover only under override; bit 13 kept zero then
// - override with auto off: bit 13 zero normal pairs, one swapped
// - bit 10 holds 10 Mb/s receive PLL on reference, blocking 10 Mb/s reception
// - read-only bit 4 reports 10 Mb/s receive polarity, one reversed
// - interrupt source bits 7 to 1 latch high on their events
// - mask low byte enables matching sources, reset masks all
// - status bit 12 reads one once negotiation finished in a negotiating mode (mode bit 2 set), else zero
// - bits 4-2 report resolved speed/duplex: 001, 101, 010, 110
`timescale 1ns/10ps
`default_nettype none
module pvmr_top #(
  parameter int ENERGY_TIMEOUT = pvmr_pkg::ENERGY_TIMEOUT_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic soft_reset_in,
  input wire pvmr_pkg::pvmr_req_t mgmt_req_in,
  output logic [15:0] mgmt_rdata_out,
  output logic mgmt_ack_out,
  input wire pvmr_pkg::pvmr_neg_t neg_in,
  input wire logic line_energy_in,
  input wire logic [2:0] mode_strap_in,
  input wire logic [4:0] addr_strap_in,
  input wire logic crossover_auto_strap_in,
  output logic an_enable_out,
  output logic [3:0] adv_abilities_out,
  output logic crs_on_tx_out,
  output logic speed100_out,
  output logic full_duplex_out,
  output logic energy_detect_powerdown_en_out,
  output logic rx_pll_ref_lock_out,
  output logic mdix_auto_out,
  output logic mdix_swap_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_r;
  logic rstn_r;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_r <= 1'b0;
      rstn_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rstn_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  pvmr_pkg::pvmr_state_t st_r;
  pvmr_pkg::pvmr_state_t st_nxt;

  logic hit;
  logic rd_hit;
  logic wr_hit;
  logic energy_rise;
  logic an_done_rise;
  logic [7:0] irq_set;
  logic spd100;
  logic fdx;
  logic [2:0] speed_code;

  localparam int ENERGY_CNT_W_L = pvmr_pkg::ENERGY_CNT_W;

  logic [ENERGY_CNT_W_L-1:0] timeout_last;

  assign timeout_last = ENERGY_CNT_W_L'(ENERGY_TIMEOUT - 1);

  // the device only answers frames carrying its own address
  assign hit = (mgmt_req_in.phy_addr == st_r.mgmt_address_field);
  assign rd_hit = hit && mgmt_req_in.rd;
  assign wr_hit = hit && mgmt_req_in.wr;

  always_comb begin
    spd100 = st_r.mode[1];
    fdx = st_r.mode[0];
    case (st_r.mode)
      pvmr_pkg::MODE_10HD, pvmr_pkg::MODE_10FD,
      pvmr_pkg::MODE_100HD, pvmr_pkg::MODE_100FD: begin
        spd100 = st_r.mode[1];
        fdx = st_r.mode[0];
      end
      pvmr_pkg::MODE_AN_100HD, pvmr_pkg::MODE_REPEATER: begin
        spd100 = 1'b1;
        fdx = 1'b0;
      end
      pvmr_pkg::MODE_ALL: begin
        spd100 = neg_in.speed100;
        fdx = neg_in.full_duplex;
      end
      default: begin
        spd100 = 1'b1;
        fdx = 1'b0;
      end
    endcase
  end

  assign speed_code = {fdx, spd100, ~spd100};

  // rises come from registered state, so the flag logic never loops through st_nxt
  assign energy_rise = st_r.energy_sync[1] && !st_r.energy_present;
  // negotiation done is a level; only its rise is an event
  assign an_done_rise = neg_in.an_done && !st_r.an_done_d;
  assign irq_set = {energy_rise, an_done_rise, neg_in.remote_fault, neg_in.link_down,
                    neg_in.partner_ack, neg_in.pd_fault, neg_in.page_rx, 1'b0};

  always_comb begin
    st_nxt = st_r;
    // pin synchronisers
    st_nxt.energy_sync = {st_r.energy_sync[0], line_energy_in};
    st_nxt.xover_strap_sync = {st_r.xover_strap_sync[0], crossover_auto_strap_in};
    st_nxt.mode_strap_s1 = mode_strap_in;
    st_nxt.mode_strap_s2 = st_r.mode_strap_s1;
    st_nxt.addr_strap_s1 = addr_strap_in;
    st_nxt.addr_strap_s2 = st_r.addr_strap_s1;
    st_nxt.an_done_d = neg_in.an_done;

    // energy timeout keeps running through a software reset
    if (st_r.energy_sync[1]) begin
      st_nxt.energy_cnt = '0;
      st_nxt.energy_present = 1'b1;
    end else if (st_r.energy_cnt >= timeout_last) begin
      st_nxt.energy_present = 1'b0;
    end else begin
      st_nxt.energy_cnt = st_r.energy_cnt + 1'b1;
    end

    // straps are taken once; the synchronisers restart from zero at release,
    // so capture waits until the second stage holds the pins
    if (!st_r.straps_taken) begin
      if (st_r.strap_age == pvmr_pkg::STRAP_SETTLE) begin
        st_nxt.straps_taken = 1'b1;
        st_nxt.mode = st_r.mode_strap_s2;
        st_nxt.mgmt_address_field = st_r.addr_strap_s2;
      end else begin
        st_nxt.strap_age = st_r.strap_age + 2'h1;
      end
    end

    // management read answers one cycle after the request
    st_nxt.ack = rd_hit || wr_hit;
    st_nxt.rdata = st_r.rdata;
    if (rd_hit) begin
      st_nxt.rdata = '0;
      case (mgmt_req_in.reg_idx)
        pvmr_pkg::IDX_EXPANSION: begin
          st_nxt.rdata[pvmr_pkg::EXP_PD_FAULT] = st_r.exp_pd_fault;
          st_nxt.rdata[pvmr_pkg::EXP_PARTNER_NP] = neg_in.partner_np;
          st_nxt.rdata[pvmr_pkg::EXP_PAGE_RX] = st_r.exp_page_rx;
          st_nxt.rdata[pvmr_pkg::EXP_PARTNER_ABLE] = neg_in.partner_able;
        end
        pvmr_pkg::IDX_MODE_CTRL: begin
          st_nxt.rdata[pvmr_pkg::MC_EDPD_EN] = st_r.energy_detect_powerdown_en;
          st_nxt.rdata[pvmr_pkg::MC_ENERGY] = st_r.energy_present;
        end
        pvmr_pkg::IDX_SPECIAL_MODES: begin
          st_nxt.rdata[pvmr_pkg::SM_MODE_LSB +: 3] = st_r.mode;
          st_nxt.rdata[pvmr_pkg::SM_ADDR_LSB +: 5] = st_r.mgmt_address_field;
        end
        pvmr_pkg::IDX_XOVER_CTRL: begin
          st_nxt.rdata[pvmr_pkg::XC_OVERRIDE] = st_r.mdix_override;
          st_nxt.rdata[pvmr_pkg::XC_AUTO_EN] = st_r.mdix_auto;
          st_nxt.rdata[pvmr_pkg::XC_STATE] = st_r.mdix_state;
          st_nxt.rdata[pvmr_pkg::XC_PLL_LOCK] = st_r.rx_pll_ref_lock;
          st_nxt.rdata[pvmr_pkg::XC_POLARITY] = neg_in.rx_pol_rev;
        end
        pvmr_pkg::IDX_IRQ_FLAGS: begin
          st_nxt.rdata[7:0] = st_r.irq_flags;
        end
        pvmr_pkg::IDX_IRQ_MASK: begin
          st_nxt.rdata[7:0] = st_r.irq_mask;
        end
        pvmr_pkg::IDX_LINK_STATUS: begin
          st_nxt.rdata[pvmr_pkg::LS_AUTODONE] = neg_in.an_done && an_enable_out;
          st_nxt.rdata[pvmr_pkg::LS_RSVD_LSB +: 7] = st_r.ls_rsvd;
          st_nxt.rdata[pvmr_pkg::LS_SPEED_LSB +: 3] = speed_code;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    // latch-high bits clear on read; a same-cycle event wins over the clear
    if (rd_hit && mgmt_req_in.reg_idx == pvmr_pkg::IDX_EXPANSION) begin
      st_nxt.exp_pd_fault = 1'b0;
      st_nxt.exp_page_rx = 1'b0;
    end
    if (neg_in.pd_fault) begin
      st_nxt.exp_pd_fault = 1'b1;
    end
    if (neg_in.page_rx) begin
      st_nxt.exp_page_rx = 1'b1;
    end
    if (rd_hit && mgmt_req_in.reg_idx == pvmr_pkg::IDX_IRQ_FLAGS) begin
      st_nxt.irq_flags = irq_set;
    end else begin
      st_nxt.irq_flags = st_r.irq_flags | irq_set;
    end

    if (wr_hit) begin
      case (mgmt_req_in.reg_idx)
        pvmr_pkg::IDX_MODE_CTRL: begin
          st_nxt.energy_detect_powerdown_en = mgmt_req_in.wdata[pvmr_pkg::MC_EDPD_EN];
        end
        pvmr_pkg::IDX_SPECIAL_MODES: begin
          st_nxt.mode = mgmt_req_in.wdata[pvmr_pkg::SM_MODE_LSB +: 3];
          st_nxt.mgmt_address_field = mgmt_req_in.wdata[pvmr_pkg::SM_ADDR_LSB +: 5];
        end
        pvmr_pkg::IDX_XOVER_CTRL: begin
          st_nxt.mdix_override = mgmt_req_in.wdata[pvmr_pkg::XC_OVERRIDE];
          st_nxt.mdix_auto = mgmt_req_in.wdata[pvmr_pkg::XC_AUTO_EN];
          st_nxt.mdix_state = mgmt_req_in.wdata[pvmr_pkg::XC_STATE];
          st_nxt.rx_pll_ref_lock = mgmt_req_in.wdata[pvmr_pkg::XC_PLL_LOCK];
        end
        pvmr_pkg::IDX_IRQ_MASK: begin
          st_nxt.irq_mask = mgmt_req_in.wdata[7:0];
        end
        pvmr_pkg::IDX_LINK_STATUS: begin
          st_nxt.ls_rsvd = mgmt_req_in.wdata[pvmr_pkg::LS_RSVD_LSB +: 7];
        end
        default: begin
          st_nxt.ls_rsvd = st_r.ls_rsvd;
        end
      endcase
    end

    // software reset: mode, address and PLL lock survive, energy-present too
    if (soft_reset_in) begin
      st_nxt.energy_detect_powerdown_en = 1'b0;
      st_nxt.mdix_override = 1'b0;
      st_nxt.mdix_auto = 1'b0;
      st_nxt.mdix_state = 1'b0;
      st_nxt.irq_mask = pvmr_pkg::IRQ_MASK_RESET;
      st_nxt.irq_flags = irq_set;
      st_nxt.exp_pd_fault = neg_in.pd_fault;
      st_nxt.exp_page_rx = neg_in.page_rx;
      st_nxt.ls_rsvd = pvmr_pkg::LS_RSVD_RESET;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_r) begin
    if (!rstn_r) begin
      st_r <= '0;
      st_r.mgmt_address_field <= pvmr_pkg::ADDR_RESET;
      st_r.energy_present <= 1'b1;
      st_r.ls_rsvd <= pvmr_pkg::LS_RSVD_RESET;
      st_r.irq_mask <= pvmr_pkg::IRQ_MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign mgmt_rdata_out = st_r.rdata;
  assign mgmt_ack_out = st_r.ack;
  assign an_enable_out = st_r.mode[2];
  assign adv_abilities_out = (st_r.mode == pvmr_pkg::MODE_ALL) ? pvmr_pkg::ADV_ALL :
                             (st_r.mode[2:1] == 2'b10) ? pvmr_pkg::ADV_100HD : 4'h0;
  // repeater and full-duplex modes keep carrier sense off during transmit
  assign crs_on_tx_out = !fdx && (st_r.mode != pvmr_pkg::MODE_REPEATER);
  assign speed100_out = spd100;
  assign full_duplex_out = fdx;
  assign energy_detect_powerdown_en_out = st_r.energy_detect_powerdown_en;
  assign rx_pll_ref_lock_out = st_r.rx_pll_ref_lock;
  assign mdix_auto_out = st_r.mdix_override ? st_r.mdix_auto
                                            : st_r.xover_strap_sync[1];
  assign mdix_swap_out = st_r.mdix_override && !st_r.mdix_auto && st_r.mdix_state;
  assign irq_out = |(st_r.irq_flags & st_r.irq_mask & 8'hfe);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_PD_FAULT_LATCH: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    neg_in.pd_fault |=> st_r.exp_pd_fault)
    else $error("parallel fault not latched");
  AST_PAGE_LATCH: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    neg_in.page_rx |=> st_r.exp_page_rx)
    else $error("page received not latched");
  AST_EDPD_OUT: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    (wr_hit && mgmt_req_in.reg_idx == pvmr_pkg::IDX_MODE_CTRL && !soft_reset_in)
    |=> energy_detect_powerdown_en_out == $past(mgmt_req_in.wdata[13]))
    else $error("power-down enable not written");
  AST_ENERGY_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    st_r.energy_sync[1] |=> st_r.energy_present)
    else $error("energy present not set");
  AST_ENERGY_SOFT: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    (soft_reset_in && !st_r.energy_sync[1] && st_r.energy_cnt < timeout_last)
    |=> st_r.energy_present == $past(st_r.energy_present))
    else $error("energy present changed by soft reset");
  AST_FORCED_MODE: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    (st_r.mode[2] == 1'b0) |-> (!an_enable_out && speed100_out == st_r.mode[1]
    && full_duplex_out == st_r.mode[0]))
    else $error("forced mode wrong");
  AST_ADV_ALL: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    (st_r.mode == pvmr_pkg::MODE_ALL) |-> (adv_abilities_out == 4'hf
    && speed100_out == neg_in.speed100))
    else $error("all-capable mode wrong");
  AST_SWAP: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    mdix_swap_out |-> (st_r.mdix_override && !mdix_auto_out))
    else $error("swap without manual override");
  AST_IRQ_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    neg_in.link_down |=> st_r.irq_flags[pvmr_pkg::IRQ_LINK_DOWN])
    else $error("link down flag not latched");
  AST_IRQ_OUT: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    (st_r.irq_flags[6] && st_r.irq_mask[6]) |-> irq_out)
    else $error("interrupt not raised");
  AST_SPEED_CODE: assert property (@(posedge clk_sys_in) disable iff (!rstn_r)
    (rd_hit && mgmt_req_in.reg_idx == pvmr_pkg::IDX_LINK_STATUS)
    |=> mgmt_rdata_out[4:2] == {$past(fdx), $past(spd100), !$past(spd100)})
    else $error("speed code wrong");

endmodule : pvmr_top
`default_nettype wire

/* core/pvmr_pkg.sv */
// pvmr_pkg: constants and carrier types of the upper management register set
// assumes: included before core/pvmr_top.sv; no other dependencies
package pvmr_pkg;
  // register indices on the management port
  localparam logic [4:0] IDX_EXPANSION = 5'h06;
  localparam logic [4:0] IDX_MODE_CTRL = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] IDX_XOVER_CTRL = 5'h1b;
  localparam logic [4:0] IDX_IRQ_FLAGS = 5'h1d;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h1e;
  localparam logic [4:0] IDX_LINK_STATUS = 5'h1f;
  // field positions
  localparam int EXP_PARTNER_ABLE = 0;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_NP_ABLE = 2;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_PD_FAULT = 4;
  localparam int MC_EDPD_EN = 13;
  localparam int MC_ENERGY = 1;
  localparam int SM_MODE_LSB = 5;
  localparam int SM_ADDR_LSB = 0;
  localparam int XC_OVERRIDE = 15;
  localparam int XC_AUTO_EN = 14;
  localparam int XC_STATE = 13;
  localparam int XC_PLL_LOCK = 10;
  localparam int XC_POLARITY = 4;
  localparam int IRQ_ENERGY = 7;
  localparam int IRQ_AN_DONE = 6;
  localparam int IRQ_REMOTE_FAULT = 5;
  localparam int IRQ_LINK_DOWN = 4;
  localparam int IRQ_PARTNER_ACK = 3;
  localparam int IRQ_PD_FAULT = 2;
  localparam int IRQ_PAGE_RX = 1;
  localparam int LS_AUTODONE = 12;
  localparam int LS_RSVD_LSB = 5;
  localparam int LS_SPEED_LSB = 2;
  // reset values
  localparam logic [4:0] ADDR_RESET = 5'h01;
  localparam logic [6:0] LS_RSVD_RESET = 7'h02;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  // edges after reset release before the strap synchronisers hold pin values
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // operating modes
  localparam logic [2:0] MODE_10HD = 3'h0;
  localparam logic [2:0] MODE_10FD = 3'h1;
  localparam logic [2:0] MODE_100HD = 3'h2;
  localparam logic [2:0] MODE_100FD = 3'h3;
  localparam logic [2:0] MODE_AN_100HD = 3'h4;
  localparam logic [2:0] MODE_REPEATER = 3'h5;
  localparam logic [2:0] MODE_ALL = 3'h7;
  localparam logic [3:0] ADV_100HD = 4'h4;
  localparam logic [3:0] ADV_ALL = 4'hf;
  // energy timeout
  localparam int CLK_PERIOD_NS = 10;
  localparam int ENERGY_TIMEOUT_MS = 256;
  localparam int ENERGY_TIMEOUT_CYC = (ENERGY_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int ENERGY_CNT_W = 25;

  typedef struct packed {
    logic page_rx;
    logic pd_fault;
    logic partner_able;
    logic partner_np;
    logic an_done;
    logic speed100;
    logic full_duplex;
    logic remote_fault;
    logic link_down;
    logic partner_ack;
    logic rx_pol_rev;
  } pvmr_neg_t;

  typedef struct packed {
    logic [4:0] phy_addr;
    logic [4:0] reg_idx;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } pvmr_req_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [4:0] mgmt_address_field;
    logic rx_pll_ref_lock;
    logic energy_detect_powerdown_en;
    logic energy_present;
    logic [ENERGY_CNT_W-1:0] energy_cnt;
    logic mdix_override;
    logic mdix_auto;
    logic mdix_state;
    logic [7:0] irq_flags;
    logic [7:0] irq_mask;
    logic exp_pd_fault;
    logic exp_page_rx;
    logic [6:0] ls_rsvd;
    logic [15:0] rdata;
    logic ack;
    logic straps_taken;
    logic [1:0] strap_age;
    logic an_done_d;
    logic [1:0] energy_sync;
    logic [1:0] xover_strap_sync;
    logic [2:0] mode_strap_s1;
    logic [2:0] mode_strap_s2;
    logic [4:0] addr_strap_s1;
    logic [4:0] addr_strap_s2;
  } pvmr_state_t;
endpackage : pvmr_pkg

/* tb/pvmr_mgmt_model.sv */
// pvmr_mgmt_model: station management controller issuing register requests
// assumes: design takes a one-cycle rd/wr pulse and acks one cycle later
`timescale 1ns/10ps
`default_nettype none
module pvmr_mgmt_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  input wire logic ack_in,
  output var pvmr_pkg::pvmr_req_t req_out
);
  logic [4:0] addr = 5'h01;

  initial req_out = '0;

  ////////////////////////////////////////////////////////////////////////////
  // one transfer; write data is cleaned of combinations the device forbids
  task automatic xfer(input logic [4:0] idx, input logic wr, input logic [15:0] wd,
                      output logic [15:0] rd, output logic acked);
    logic [15:0] d;
    d = wd;
    if (wr && idx == pvmr_pkg::IDX_XOVER_CTRL && d[14]) d[13] = 1'b0;
    if (wr && idx == pvmr_pkg::IDX_SPECIAL_MODES && d[7:5] == 3'h6) d[7:5] = 3'h7;
    if (wr && idx == pvmr_pkg::IDX_LINK_STATUS) d[11:5] = 7'h02;
    @(negedge clk_in);
    req_out <= '{phy_addr: addr, reg_idx: idx, wr: wr, rd: !wr, wdata: d};
    @(negedge clk_in);
    // the answer stands for the whole cycle after the request edge
    acked = ack_in;
    rd = rdata_in;
    // released index and data lines show inverted values so stale data cannot pass as valid
    req_out <= '{phy_addr: addr, reg_idx: ~idx, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : xfer
endmodule : pvmr_mgmt_model
`default_nettype wire

/* tb/testbench.sv */
// testbench: random and corner checks of the upper management register set
// assumes: pvmr_pkg compiled first; short energy timeout of 20 cycles
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int TMO = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic soft_rst = 1'b0;
  logic energy = 1'b1;
  logic xstrap = 1'b0;
  pvmr_pkg::pvmr_req_t req;
  pvmr_pkg::pvmr_neg_t neg = '0;
  logic [15:0] rdata;
  logic ack, an_en, crs, s100, fdx, edpd, pll, mauto, mswap, irq;
  logic [3:0] adv;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [15:0] xw [6] = '{16'h0000, 16'hc000, 16'h8000, 16'ha000, 16'h0400, 16'he000};

  always #5 clk = ~clk;

  pvmr_top #(.ENERGY_TIMEOUT(TMO)) u_dut (.clk_sys_in(clk), .rstn_in(rstn),
    .soft_reset_in(soft_rst), .mgmt_req_in(req), .mgmt_rdata_out(rdata), .mgmt_ack_out(ack),
    .neg_in(neg), .line_energy_in(energy), .mode_strap_in(3'h7), .addr_strap_in(5'h01),
    .crossover_auto_strap_in(xstrap), .an_enable_out(an_en), .adv_abilities_out(adv),
    .crs_on_tx_out(crs), .speed100_out(s100), .full_duplex_out(fdx),
    .energy_detect_powerdown_en_out(edpd), .rx_pll_ref_lock_out(pll),
    .mdix_auto_out(mauto), .mdix_swap_out(mswap), .irq_out(irq));

  pvmr_mgmt_model u_mgmt (.clk_in(clk), .rdata_in(rdata), .ack_in(ack), .req_out(req));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    logic [15:0] r;
    logic a;
    u_mgmt.xfer(idx, 1'b1, d, r, a);
    chk({15'h0, a}, 16'h0001);
  endtask : wr

  task automatic rdchk(input logic [4:0] idx, input logic [15:0] m, input logic [15:0] exp);
    logic [15:0] r;
    logic a;
    u_mgmt.xfer(idx, 1'b0, 16'h0000, r, a);
    chk({15'h0, a}, 16'h0001);
    chk(r & m, exp);
  endtask : rdchk

  // {an, adv[3:0], crs, speed100, full duplex}
  function automatic logic [7:0] exp_mode(input logic [2:0] m, input logic s, input logic f);
    logic sp, fd;
    sp = m[2] ? (m == 3'h7 ? s : 1'b1) : m[1];
    fd = m[2] ? (m == 3'h7 ? f : 1'b0) : m[0];
    return {m[2], (m == 3'h7) ? pvmr_pkg::ADV_ALL : (m[2] ? pvmr_pkg::ADV_100HD : 4'h0),
            !fd && m != 3'h5, sp, fd};
  endfunction : exp_mode

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] e, msk;
    logic [5:0] ev;
    logic [2:0] m;
    logic [15:0] d;
    void'($urandom(47));
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (5) @(negedge clk);
    rdchk(pvmr_pkg::IDX_IRQ_MASK, 16'hffff, 16'h0000);
    rdchk(pvmr_pkg::IDX_MODE_CTRL, 16'hffff, 16'h0002);
    rdchk(pvmr_pkg::IDX_SPECIAL_MODES, 16'hffff, 16'h00e1);
    rdchk(pvmr_pkg::IDX_EXPANSION, 16'hffff, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      if (i == 6) continue;
      m = i[2:0];
      {neg.speed100, neg.full_duplex, neg.an_done} = 3'($urandom);
      wr(pvmr_pkg::IDX_SPECIAL_MODES, {8'h00, m, 5'h01});
      e = exp_mode(m, neg.speed100, neg.full_duplex);
      @(negedge clk);
      chk({8'h00, an_en, adv, crs, s100, fdx}, {8'h00, e});
      rdchk(pvmr_pkg::IDX_LINK_STATUS, 16'h101c,
            {3'h0, neg.an_done & m[2], 7'h00, e[0], e[1], !e[1], 2'h0});
    end
    neg.an_done = 1'b0;
    rdchk(pvmr_pkg::IDX_IRQ_FLAGS, 16'hff01, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      msk = (k == 1) ? 8'h00 : 8'($urandom);
      ev = (k == 0) ? 6'h3f : 6'($urandom);
      {neg.partner_able, neg.partner_np} = 2'($urandom);
      wr(pvmr_pkg::IDX_IRQ_MASK, {8'h00, msk});
      @(negedge clk);
      {neg.an_done, neg.remote_fault, neg.link_down, neg.partner_ack, neg.pd_fault,
       neg.page_rx} = ev;
      @(negedge clk);
      {neg.an_done, neg.remote_fault, neg.link_down, neg.partner_ack, neg.pd_fault,
       neg.page_rx} = 6'h00;
      @(negedge clk);
      chk({15'h0, irq}, {15'h0, |({1'b0, ev, 1'b0} & msk)});
      rdchk(pvmr_pkg::IDX_EXPANSION, 16'h001f,
            {11'h0, ev[1], neg.partner_np, 1'b0, ev[0], neg.partner_able});
      rdchk(pvmr_pkg::IDX_EXPANSION, 16'h0012, 16'h0000);
      rdchk(pvmr_pkg::IDX_IRQ_FLAGS, 16'h00fe, {8'h00, 1'b0, ev, 1'b0});
      rdchk(pvmr_pkg::IDX_IRQ_FLAGS, 16'h00fe, 16'h0000);
    end
    for (int k = 0; k < 6; k++) begin
      xstrap = 1'($urandom);
      neg.rx_pol_rev = k[0];
      repeat (3) @(negedge clk);
      wr(pvmr_pkg::IDX_XOVER_CTRL, xw[k]);
      d = xw[k];
      if (d[14]) d[13] = 1'b0;
      @(negedge clk);
      chk({13'h0, mauto, pll, mswap},
          {13'h0, d[15] ? d[14] : xstrap, d[10], d[15] & !d[14] & d[13]});
      rdchk(pvmr_pkg::IDX_XOVER_CTRL, 16'he410, d | {11'h0, k[0], 4'h0});
    end
    wr(pvmr_pkg::IDX_LINK_STATUS, 16'h0000);
    energy = 1'b0;
    repeat (10) @(negedge clk);
    rdchk(pvmr_pkg::IDX_MODE_CTRL, 16'h0002, 16'h0002);
    repeat (30) @(negedge clk);
    rdchk(pvmr_pkg::IDX_MODE_CTRL, 16'h0002, 16'h0000);
    wr(pvmr_pkg::IDX_MODE_CTRL, 16'h2000);
    @(negedge clk);
    chk({15'h0, edpd}, 16'h0001);
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    rdchk(pvmr_pkg::IDX_MODE_CTRL, 16'h2002, 16'h0000);
    rdchk(pvmr_pkg::IDX_SPECIAL_MODES, 16'h00ff, 16'h00e1);
    energy = 1'b1;
    repeat (5) @(negedge clk);
    rdchk(pvmr_pkg::IDX_MODE_CTRL, 16'h0002, 16'h0002);
    chk({15'h0, irq}, 16'h0000);
    rdchk(pvmr_pkg::IDX_IRQ_FLAGS, 16'h0080, 16'h0080);
    wr(pvmr_pkg::IDX_SPECIAL_MODES, 16'h00e3);
    u_mgmt.addr = 5'h03;
    rdchk(pvmr_pkg::IDX_SPECIAL_MODES, 16'h00ff, 16'h00e3);
    energy = 1'b0;
    repeat (40) @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    u_mgmt.addr = 5'h01;
    repeat (5) @(negedge clk);
    rdchk(pvmr_pkg::IDX_MODE_CTRL, 16'h0002, 16'h0002);
    summarize();
  end
endmodule : testbench
`default_nettype wire
